// File: shared/spc_consts.svh
`ifndef SPC_CONSTS_SVH
`define SPC_CONSTS_SVH

// ============================================================
// register offsets
`define SPC_OFF_CTRL      8'h00
`define SPC_OFF_MODE      8'h04
`define SPC_OFF_RXDATA    8'h08
`define SPC_OFF_TXDATA    8'h0C
`define SPC_OFF_STATUS    8'h10
`define SPC_OFF_IRQ_SET   8'h14
`define SPC_OFF_IRQ_CLR   8'h18
`define SPC_OFF_IRQ_VIEW  8'h1C
`define SPC_OFF_CFG0      8'h30

// ============================================================
// field positions
`define SPC_CTRL_EN_BIT       0
`define SPC_CTRL_DIS_BIT      1
`define SPC_MODE_PRESCALE_BIT 3
`define SPC_TX_SEL_LSB        16
`define SPC_TX_LAST_BIT       24
`define SPC_ST_ENABLED_BIT    16
`define SPC_ST_IDLE_LVL_BIT   17
`define SPC_ST_FREE_LVL_BIT   18

// event bits, shared by status, enable, disable and mask views
`define SPC_EV_RX_READY     0
`define SPC_EV_TX_FREE      1
`define SPC_EV_FAULT        2
`define SPC_EV_OVERFLOW     3
`define SPC_EV_RX_DONE      4
`define SPC_EV_TX_DONE      5
`define SPC_EV_RX_EXHAUST   6
`define SPC_EV_TX_EXHAUST   7
`define SPC_EV_SEL_RISE     8
`define SPC_EV_ALL_IDLE     9
`define SPC_NUM_EVENTS      10

// ============================================================
// reset values and timing
`define SPC_CFG_RESET       32'h0000_0000
`define SPC_CFG_WR_MASK     32'hFFFF_FFFB
`define SPC_PRESCALE        32
`define SPC_GAP_UNIT        32
`define SPC_MIN_BITS        8
`define SPC_MAX_BITS_CODE   4'h8
`define SPC_NUM_SEL         4

`endif

// File: shared/spc_pkg.sv
`default_nettype none
package spc_pkg;

    typedef struct packed {
        logic [7:0] gap;
        logic [7:0] lead;
        logic [7:0] baud;
        logic [3:0] bits;
        logic       hold;
        logic       rsv;
        logic       sample_edge;
        logic       idle_level;
    } spc_cfg_s;

    typedef struct packed {
        logic [15:0] data;
        logic [1:0]  sel;
        logic        last;
    } spc_txreq_s;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_LEAD  = 4'h2,
        ST_SHIFT = 4'h4,
        ST_GAP   = 4'h8
    } spc_state_e;

endpackage
`default_nettype wire

// File: logic/spc_tick_div.sv
`timescale 1ns/1ns
`default_nettype none
`include "spc_consts.svh"

module spc_tick_div
#(
    parameter int RATIO = `SPC_PRESCALE
)
(
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic prescale_on,
    output logic      tick
);

    logic [$clog2(RATIO)-1:0] cnt;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n || !prescale_on)
            cnt <= '0;
        else
            cnt <= cnt + 1'b1;
    end

    assign tick = !prescale_on || (cnt == ($clog2(RATIO))'(RATIO - 1));

endmodule
`default_nettype wire

// File: logic/spc_timer.sv
`timescale 1ns/1ns
`default_nettype none

module spc_timer
#(
    parameter int CNT_W = 16
)
(
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             tick,
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] load_val,
    output logic                  fire
);

    logic [CNT_W-1:0] cnt;
    logic             armed;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            cnt   <= '0;
            armed <= 1'b0;
        end
        else if (load)
        begin
            cnt   <= load_val;
            armed <= 1'b1;
        end
        else if (tick && armed)
        begin
            if (cnt == '0)
                armed <= 1'b0;
            else
                cnt <= cnt - 1'b1;
        end
    end

    // fires on the tick that ends load_val+1 ticks
    assign fire = tick && armed && (cnt == '0);

endmodule
`default_nettype wire

// File: logic/spc_core.sv
// Behaviour
// - write to tx data clears all-idle; set once holding, shifter and gap are done
// - read-only enabled flag shows whether the serial interface is on
// - writing ones to enable-set turns matching interrupts on; zeros ignored
// - writing ones to enable-clear turns matching interrupts off; zeros ignored
// - enable view reads one per enabled interrupt, same bit layout
// - per-select idle level of the serial clock: zero low, one high
// - per-select phase: zero changes on leading edge, one samples on it
// - hold bit zero drops select after transfer; one keeps it until select changes or a character flagged last ends
// - four-bit length code 0 to 8 gives 8 to 16 bits; higher reserved
// - serial clock is master clock over baud field, times 32 when prescaled
// - lead delay: zero is half a clock period, else field ticks
// - gap delay follows every character, before next one or select release
// - gap zero keeps duty cycle; else 32 times field plus half baud ticks
// - prescale mode derives all timing from master clock divided by fixed factor
`timescale 1ns/1ns
`default_nettype none
`include "spc_consts.svh"

module spc_core
    import spc_pkg::*;
#(
    parameter int CNT_W = 16
)
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             serial_clock_out,
    output logic             serial_data_out,
    input  wire logic        serial_data_in,
    output logic      [3:0]  periph_select_lines_n,
    input  wire logic        select_in,
    input  wire logic        master_conflict_fault,
    input  wire logic        rx_count_done,
    input  wire logic        tx_count_done,
    input  wire logic        rx_counts_exhausted,
    input  wire logic        tx_counts_exhausted,
    output logic             irq
);

    // ============================================================
    // helpers
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        return addr == off;
    endfunction

    function automatic logic cfg_hit(input logic [7:0] addr);
        return (addr[7:4] == `SPC_OFF_CFG0 >> 4) && (addr[1:0] == 2'h0);
    endfunction

    // reserved length codes fall back to the widest character
    function automatic logic [4:0] nbits(input logic [3:0] code);
        return (code > `SPC_MAX_BITS_CODE) ? 5'h10 : 5'(code) + 5'(`SPC_MIN_BITS);
    endfunction

    // a zero baud field is software's fault; clamp to avoid a dead timer
    function automatic logic [CNT_W-1:0] half_lo(input logic [7:0] baud);
        return (baud[7:1] == 7'h00) ? CNT_W'(1) : CNT_W'(baud[7:1]);
    endfunction

    function automatic logic [CNT_W-1:0] half_hi(input logic [7:0] baud);
        return (baud <= 8'h01) ? CNT_W'(1) : CNT_W'(baud) - half_lo(baud);
    endfunction

    // ============================================================
    // register state
    spc_cfg_s                    cfg [`SPC_NUM_SEL];
    spc_txreq_s                  hold_q;
    logic                        hold_full;
    logic                        enabled;
    logic                        disable_pend;
    logic                        prescale_on;
    logic [`SPC_NUM_EVENTS-1:0]  status;
    logic [`SPC_NUM_EVENTS-1:0]  mask;
    logic [15:0]                 rx_data;
    logic                        rx_full;
    logic                        idle_prev;
    logic                        sel_in_prev;

    // engine state
    spc_state_e                  state;
    spc_cfg_s                    cur_cfg;
    logic [1:0]                  cur_sel;
    logic                        cur_last;
    logic                        sel_active;
    logic [15:0]                 tx_sh;
    logic [15:0]                 rx_sh;
    logic [5:0]                  edge_cnt;

    logic                        wr_ctrl;
    logic                        wr_mode;
    logic                        wr_tx;
    logic                        wr_set;
    logic                        wr_clr;
    logic                        rd_status;
    logic                        rd_rx;
    logic                        tick;
    logic                        tmr_fire;
    logic                        tmr_load;
    logic [CNT_W-1:0]            tmr_val;
    spc_cfg_s                    new_cfg;
    logic                        do_edge;
    logic                        leading;
    logic                        last_edge;
    logic                        is_sample;
    logic                        is_change;
    logic                        decide;
    logic                        chain_ok;
    logic                        idle_start;
    logic                        switch_sel;
    logic                        load_now;
    logic                        all_idle;
    logic                        rx_store;
    logic [`SPC_NUM_EVENTS-1:0]  events;

    spc_state_e                  next_state;
    logic                        next_sel_active;
    logic [1:0]                  next_cur_sel;
    logic                        next_sck;
    logic [15:0]                 next_tx_sh;
    logic [15:0]                 next_rx_sh;
    logic [5:0]                  next_edge_cnt;

    assign wr_ctrl   = reg_wr && hit(reg_addr, `SPC_OFF_CTRL);
    assign wr_mode   = reg_wr && hit(reg_addr, `SPC_OFF_MODE);
    assign wr_tx     = reg_wr && hit(reg_addr, `SPC_OFF_TXDATA);
    assign wr_set    = reg_wr && hit(reg_addr, `SPC_OFF_IRQ_SET);
    assign wr_clr    = reg_wr && hit(reg_addr, `SPC_OFF_IRQ_CLR);
    assign rd_status = reg_rd && hit(reg_addr, `SPC_OFF_STATUS);
    assign rd_rx     = reg_rd && hit(reg_addr, `SPC_OFF_RXDATA);

    // ============================================================
    // timebase
    spc_tick_div u_tick_div
    (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .prescale_on (prescale_on),
        .tick        (tick)
    );

    spc_timer #(.CNT_W(CNT_W)) u_timer
    (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .tick     (tick),
        .load     (tmr_load),
        .load_val (tmr_val),
        .fire     (tmr_fire)
    );

    // ============================================================
    // sequencing decisions
    assign new_cfg    = cfg[hold_q.sel];
    assign do_edge    = tmr_fire && (state == ST_LEAD || state == ST_SHIFT);
    assign leading    = !edge_cnt[0];
    assign last_edge  = do_edge && (edge_cnt == {nbits(cur_cfg.bits), 1'b0} - 6'h01);
    assign is_sample  = do_edge && (leading == cur_cfg.sample_edge);
    assign is_change  = do_edge && !is_sample && (edge_cnt != 6'h00) && !last_edge;
    assign decide     = (last_edge && cur_cfg.gap == 8'h00) || (state == ST_GAP && tmr_fire);
    assign chain_ok   = hold_full && hold_q.sel == cur_sel && !cur_last && enabled && !disable_pend;
    assign idle_start = state == ST_IDLE && hold_full && enabled && !disable_pend
                        && !(sel_active && hold_q.sel != cur_sel);
    assign switch_sel = state == ST_IDLE && hold_full && sel_active && hold_q.sel != cur_sel;
    assign load_now   = (decide && chain_ok) || idle_start;
    assign rx_store   = last_edge;
    assign all_idle   = state == ST_IDLE && !hold_full;

    always_comb
    begin
        next_state      = state;
        next_sel_active = sel_active;
        next_cur_sel    = cur_sel;
        next_sck        = do_edge ? !serial_clock_out : serial_clock_out;
        next_tx_sh      = is_change ? {tx_sh[14:0], 1'b0} : tx_sh;
        next_rx_sh      = is_sample ? {rx_sh[14:0], serial_data_in} : rx_sh;
        next_edge_cnt   = do_edge ? edge_cnt + 6'h01 : edge_cnt;
        tmr_load        = 1'b0;
        tmr_val         = '0;
        if (load_now)
        begin
            next_sel_active = 1'b1;
            next_cur_sel    = hold_q.sel;
            next_tx_sh      = hold_q.data << (5'h10 - nbits(new_cfg.bits));
            next_rx_sh      = '0;
            next_edge_cnt   = '0;
            tmr_load        = 1'b1;
            if (sel_active)
            begin
                // wait a low half before the next leading edge keeps the duty
                next_state = ST_SHIFT;
                tmr_val    = half_lo(new_cfg.baud) - CNT_W'(1);
            end
            else
            begin
                next_state = ST_LEAD;
                next_sck   = new_cfg.idle_level;
                tmr_val    = (new_cfg.lead == 8'h00) ? half_lo(new_cfg.baud) - CNT_W'(1)
                                                     : CNT_W'(new_cfg.lead) - CNT_W'(1);
            end
        end
        else if (switch_sel)
        begin
            next_sel_active = 1'b0;
        end
        else if (do_edge && !last_edge)
        begin
            next_state = ST_SHIFT;
            tmr_load   = 1'b1;
            tmr_val    = (leading ? half_hi(cur_cfg.baud) : half_lo(cur_cfg.baud))
                         - CNT_W'(1);
        end
        else if (last_edge && cur_cfg.gap != 8'h00)
        begin
            next_state = ST_GAP;
            tmr_load   = 1'b1;
            tmr_val    = CNT_W'(cur_cfg.gap * `SPC_GAP_UNIT) + CNT_W'(cur_cfg.baud[7:1])
                         - CNT_W'(1);
        end
        else if (decide)
        begin
            next_state      = ST_IDLE;
            next_sel_active = cur_cfg.hold && !cur_last;
        end
    end

    // ============================================================
    // engine registers and pins
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state                 <= ST_IDLE;
            sel_active            <= 1'b0;
            cur_sel               <= 2'h0;
            cur_last              <= 1'b0;
            cur_cfg               <= spc_cfg_s'(`SPC_CFG_RESET);
            tx_sh                 <= 16'h0000;
            rx_sh                 <= 16'h0000;
            edge_cnt              <= 6'h00;
            serial_clock_out      <= 1'b0;
            serial_data_out       <= 1'b0;
            periph_select_lines_n <= 4'hF;
        end
        else
        begin
            state            <= next_state;
            sel_active       <= next_sel_active;
            cur_sel          <= next_cur_sel;
            tx_sh            <= next_tx_sh;
            rx_sh            <= next_rx_sh;
            edge_cnt         <= next_edge_cnt;
            serial_clock_out <= next_sck;
            serial_data_out  <= next_tx_sh[15];
            for (int k = 0; k < `SPC_NUM_SEL; k++)
                periph_select_lines_n[k] <= !(next_sel_active && next_cur_sel == 2'(k));
            if (load_now)
            begin
                cur_cfg  <= new_cfg;
                cur_last <= hold_q.last;
            end
        end
    end

    // ============================================================
    // holding register, enable and mode
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            hold_q    <= '0;
            hold_full <= 1'b0;
        end
        else if (wr_tx)
        begin
            // a write beside a load refills the just-emptied holder
            hold_q.data <= reg_wdata[15:0];
            hold_q.sel  <= reg_wdata[`SPC_TX_SEL_LSB +: 2];
            hold_q.last <= reg_wdata[`SPC_TX_LAST_BIT];
            hold_full   <= 1'b1;
        end
        else if (load_now)
        begin
            hold_full <= 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            enabled      <= 1'b0;
            disable_pend <= 1'b0;
            prescale_on  <= 1'b0;
        end
        else
        begin
            if (wr_mode)
                prescale_on <= reg_wdata[`SPC_MODE_PRESCALE_BIT];
            // disable waits for the current character; disable beats enable
            if (wr_ctrl && reg_wdata[`SPC_CTRL_DIS_BIT])
                disable_pend <= 1'b1;
            else if (wr_ctrl && reg_wdata[`SPC_CTRL_EN_BIT])
            begin
                enabled      <= 1'b1;
                disable_pend <= 1'b0;
            end
            else if (disable_pend && state == ST_IDLE)
            begin
                enabled      <= 1'b0;
                disable_pend <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            for (int k = 0; k < `SPC_NUM_SEL; k++)
                cfg[k] <= spc_cfg_s'(`SPC_CFG_RESET);
        else if (reg_wr && cfg_hit(reg_addr))
            cfg[reg_addr[3:2]] <= spc_cfg_s'(reg_wdata & `SPC_CFG_WR_MASK);
    end

    // ============================================================
    // receive word
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            rx_data <= 16'h0000;
            rx_full <= 1'b0;
        end
        else if (rx_store)
        begin
            rx_data <= is_sample ? {rx_sh[14:0], serial_data_in} : rx_sh;
            rx_full <= 1'b1;
        end
        else if (rd_rx)
        begin
            rx_full <= 1'b0;
        end
    end

    // ============================================================
    // events, status, mask, interrupt
    always_comb
    begin
        events                       = '0;
        events[`SPC_EV_RX_READY]     = rx_store;
        events[`SPC_EV_TX_FREE]      = load_now || (wr_ctrl && reg_wdata[`SPC_CTRL_EN_BIT]
                                       && !reg_wdata[`SPC_CTRL_DIS_BIT]);
        events[`SPC_EV_FAULT]        = master_conflict_fault;
        events[`SPC_EV_OVERFLOW]     = rx_store && rx_full && !rd_rx;
        events[`SPC_EV_RX_DONE]      = rx_count_done;
        events[`SPC_EV_TX_DONE]      = tx_count_done;
        events[`SPC_EV_RX_EXHAUST]   = rx_counts_exhausted;
        events[`SPC_EV_TX_EXHAUST]   = tx_counts_exhausted;
        events[`SPC_EV_SEL_RISE]     = select_in && !sel_in_prev;
        events[`SPC_EV_ALL_IDLE]     = all_idle && !idle_prev;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            status      <= '0;
            idle_prev   <= 1'b1;
            sel_in_prev <= 1'b1;
        end
        else
        begin
            idle_prev   <= all_idle;
            sel_in_prev <= select_in;
            // a set in the clearing read's cycle survives
            status <= (rd_status ? '0 : status) | events;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            mask <= '0;
        else if (wr_set)
            mask <= mask | reg_wdata[`SPC_NUM_EVENTS-1:0];
        else if (wr_clr)
            mask <= mask & ~reg_wdata[`SPC_NUM_EVENTS-1:0];
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= |(status & mask);
    end

    // ============================================================
    // read port: data only in the cycle after the strobe
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || !reg_rd)
            reg_rdata <= 32'h0000_0000;
        else if (hit(reg_addr, `SPC_OFF_STATUS))
        begin
            reg_rdata                       <= 32'(status);
            reg_rdata[`SPC_ST_ENABLED_BIT]  <= enabled;
            reg_rdata[`SPC_ST_IDLE_LVL_BIT] <= all_idle;
            reg_rdata[`SPC_ST_FREE_LVL_BIT] <= !hold_full;
        end
        else if (hit(reg_addr, `SPC_OFF_IRQ_VIEW))
            reg_rdata <= 32'(mask);
        else if (hit(reg_addr, `SPC_OFF_RXDATA))
            reg_rdata <= {8'h00, 6'h00, cur_sel, rx_data};
        else if (hit(reg_addr, `SPC_OFF_MODE))
            reg_rdata <= 32'(prescale_on) << `SPC_MODE_PRESCALE_BIT;
        else if (cfg_hit(reg_addr))
            reg_rdata <= 32'(cfg[reg_addr[3:2]]);
        else
            reg_rdata <= 32'h0000_0000;
    end

endmodule
`default_nettype wire

// File: verif/spc_core_asserts.sv
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// port checker
module spc_core_asserts
(
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        serial_clock_out,
    input wire logic [3:0]  periph_select_lines_n,
    input wire logic        irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    rd_idle_zero_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data not zero outside read slot");
    set_view_a: assert property (reg_wr && reg_addr == 8'h14 ##1 !reg_wr ##1 reg_rd
        && reg_addr == 8'h1C |=> (reg_rdata[9:0] & $past(reg_wdata[9:0], 3))
        == $past(reg_wdata[9:0], 3))
        else $error("enable-set bit missing from mask view");
    clr_view_a: assert property (reg_wr && reg_addr == 8'h18 ##1 !reg_wr ##1 reg_rd
        && reg_addr == 8'h1C |=> (reg_rdata[9:0] & $past(reg_wdata[9:0], 3)) == 10'h000)
        else $error("enable-clear bit still in mask view");
    view_width_a: assert property (reg_rd && reg_addr == 8'h1C |=> reg_rdata[31:10] == 22'h0)
        else $error("mask view upper bits not zero");
    irq_off_a: assert property (reg_wr && reg_addr == 8'h18 && reg_wdata[9:0] == 10'h3FF
        |=> ##1 !irq)
        else $error("interrupt high with all events disabled");
    sel_onehot_a: assert property ($onehot0(~periph_select_lines_n))
        else $error("more than one select active");
    sel_start_a: assert property (reg_wr && reg_addr == 8'h0C && &periph_select_lines_n
        |-> ##2 (periph_select_lines_n == ~(4'h1 << $past(reg_wdata[17:16], 2))
        || &periph_select_lines_n))
        else $error("wrong select line driven for transfer");
    sck_idle_a: assert property (&periph_select_lines_n && $past(&periph_select_lines_n)
        && !$past(reg_wr) && !$past(reg_wr, 2) |-> $stable(serial_clock_out))
        else $error("serial clock moved while nothing selected");
endmodule

bind spc_core spc_core_asserts u_chk (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .serial_clock_out, .periph_select_lines_n, .irq);
`default_nettype wire

// File: verif/spc_periph_model.sv
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// far-side peripheral: echoes the master's data while selected
module spc_periph_model
(
    input  wire logic       core_clk,
    input  wire logic [3:0] sel_n,
    input  wire logic       mosi,
    output logic            miso
);
    logic junk = 1'b0;
    // released line toggles so a stale value cannot pass for data
    always @(posedge core_clk) junk <= ~junk;
    assign miso = (&sel_n) ? junk : mosi;
endmodule
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        core_clk;
    logic        rst_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [5:0]  ev = 6'h00;
    logic [31:0] reg_rdata;
    logic        sck;
    logic        mosi;
    logic        miso;
    logic [3:0]  sel_n;
    logic        irq;
    logic [31:0] d;
    logic        psck = 1'b0;
    logic [3:0]  psel = 4'hF;
    int          fails = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          tog = 0;
    int          first = 0;
    int          last = 0;
    int          b;
    logic [31:0] cfgv [3] = '{32'h0002_0401, 32'h0002_0682, 32'h0002_0401};
    logic [15:0] tdat [3] = '{16'h00A5, 16'hC3A5, 16'h005A};
    int          nb [3] = '{8, 16, 8};
    int          hb [3] = '{2, 3, 64};

    spc_core DUT (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .serial_clock_out(sck), .serial_data_out(mosi), .serial_data_in(miso),
        .periph_select_lines_n(sel_n), .select_in(ev[5]), .master_conflict_fault(ev[0]),
        .rx_count_done(ev[1]), .tx_count_done(ev[2]), .rx_counts_exhausted(ev[3]),
        .tx_counts_exhausted(ev[4]), .irq);
    spc_periph_model u_peer (.core_clk, .sel_n, .mosi, .miso);

    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // ============================================================
    // clock edge monitor; the edge that asserts a select is not counted,
    // the last edge may coincide with the select release and is counted
    always @(negedge core_clk)
    begin
        cyc++;
        if (psel != 4'hF && sck !== psck)
        begin
            if (tog == 0)
                first = cyc;
            last = cyc;
            tog++;
        end
        psck = sck;
        psel = sel_n;
    end

    // ============================================================
    // bus tasks
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [7:0] a);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
        @(posedge core_clk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ============================================================
    // test sequence
    initial
    begin
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        wr(8'h00, 32'h0000_0001);
        rd(8'h10);
        chk(d[16], 1);
        rd(8'h20);
        chk(d, 0);
        wr(8'h14, 32'hFFFF_FFFF);
        rd(8'h1C);
        chk(d, 32'h0000_03FF);
        wr(8'h18, 32'h0000_0155);
        rd(8'h1C);
        chk(d, 32'h0000_02AA);
        wr(8'h14, 32'h0000_0000);
        rd(8'h1C);
        chk(d, 32'h0000_02AA);
        for (int i = 0; i < 6; i++)
        begin
            b = (i == 0) ? 2 : ((i == 5) ? 8 : i + 3);
            wr(8'h18, 32'h0000_03FF);
            wr(8'h14, 32'h1 << b);
            rd(8'h10);
            @(negedge core_clk);
            chk(irq, 0);
            @(posedge core_clk);
            ev[i] <= 1'b1;
            @(posedge core_clk);
            ev[i] <= 1'b0;
            @(posedge core_clk);
            @(negedge core_clk);
            chk(irq, 1);
            @(posedge core_clk);
            rd(8'h10);
            chk(d[b], 1);
            rd(8'h10);
            chk(d[b], 0);
        end
        for (int s = 0; s < 4; s++)
        begin
            rd(8'h30 + 8'(4 * s));
            chk(d, 0);
            wr(8'h30 + 8'(4 * s), 32'hFFFF_FFFF);
            rd(8'h30 + 8'(4 * s));
            chk(d, 32'hFFFF_FFFB);
        end
        for (int t = 0; t < 3; t++)
        begin
            if (t == 2)
                wr(8'h04, 32'h0000_0008);
            wr(8'h34, cfgv[t]);
            tog = 0;
            wr(8'h0C, {7'h00, 1'b1, 6'h00, 2'h1, tdat[t]});
            rd(8'h10);
            chk(d[17], 0);
            for (int k = 0; k < 2000 && !(tog == 2 * nb[t] && sel_n === 4'hF); k++)
                @(posedge core_clk);
            repeat (4) @(posedge core_clk);
            chk(sck, cfgv[t][0]);
            chk(tog, 2 * nb[t]);
            chk(last - first, (2 * nb[t] - 1) * hb[t]);
            rd(8'h08);
            chk(d, {14'h0, 2'h1, tdat[t]});
            rd(8'h10);
            chk(d[9], 1);
        end
        wr(8'h00, 32'h0000_0002);
        repeat (2) @(posedge core_clk);
        rd(8'h10);
        chk(d[16], 0);
        close_out;
    end

    initial
    begin
        #400_000;
        fails++;
        close_out;
    end
endmodule
`default_nettype wire
